// ===== tacho_cfg.svh
// tacho_cfg.svh: offsets, field positions, reset values and timing counts
// assumes a 100 MHz pclk; included by bare name
`ifndef TACHO_CFG_SVH
`define TACHO_CFG_SVH

`define CLK_HZ            100000000
`define WINDOW_1S_MS      1000
`define INTERVAL_200_MS   200
`define INTERVAL_CONT_MS  10
`define GAP_MIN_MS        20
`define KEY_HOLD_MS       1000
`define CYC_PER_MS        (`CLK_HZ / 1000)
`define WINDOW_CYC        (`WINDOW_1S_MS * `CYC_PER_MS)
`define INT200_CYC        (`INTERVAL_200_MS * `CYC_PER_MS)
`define INTCONT_CYC       (`INTERVAL_CONT_MS * `CYC_PER_MS)
`define KEY_HOLD_CYC      (`KEY_HOLD_MS * `CYC_PER_MS)
`define ONS_PER_UNIT      1000
`define ALARM_MAX         9999

`define REG_CTRL          12'h000
`define REG_ALARM1        12'h004
`define REG_ALARM2        12'h008
`define REG_STATUS        12'h00C
`define REG_VALUE         12'h010
`define REG_ONMON1        12'h014
`define REG_ONMON2        12'h018
`define REG_SWMON         12'h01C
`define REG_SETPT         12'h020

`define CTRL_WIDTH_BIT    0
`define CTRL_PERIOD_BIT   1
`define CTRL_CONT_BIT     2
`define CTRL_CFG_LSB      4
`define CTRL_KP_LSB       8
`define CFG_RESET         4'h0
`define CFG_RESET_2STAGE  4'h1
`define KP_RESET          3'h0
`define SETPT_RESET       32'h0000_0000
`endif

// ===== tacho_pkg.sv
// tacho_pkg: shared types for the tachometer measurement block
// assumes tacho_cfg.svh is compiled alongside
package tacho_pkg;
  typedef enum logic [1:0] {
    st_run    = 2'b00,
    st_armed  = 2'b01,
    st_config = 2'b10
  } mode_type;
  typedef logic [2:0] protect_type;
endpackage

// ===== tacho_pulse_measure_ctrl.sv
// tacho_pulse_measure_ctrl: tachometer core with key, hold and alarm control
// assumes an APB master on pclk; pins from outside are asynchronous
`timescale 1ns/1ps
`default_nettype none
`include "tacho_cfg.svh"
module tacho_pulse_measure_ctrl #(
  parameter logic        TWO_STAGE   = 1'b0,               // two-stage variant
  parameter int unsigned WINDOW_CYC  = `WINDOW_CYC,         // one-second window
  parameter int unsigned INT200_CYC  = `INT200_CYC,         // 200 ms interval
  parameter int unsigned INTCONT_CYC = `INTCONT_CYC,        // 10 ms interval
  parameter int unsigned KEY_CYC     = `KEY_HOLD_CYC        // up key hold time
) (
  input  wire logic                  pclk,          // 100 MHz clock
  input  wire logic                  presetn,       // async reset, low
  input  wire logic                  psel,          // apb select
  input  wire logic                  penable,       // apb enable
  input  wire logic                  pwrite,        // apb direction
  input  wire logic [11:0]           paddr,         // apb byte address
  input  wire logic [31:0]           pwdata,        // apb write data
  output logic [31:0]                prdata,        // apb read data
  output logic                       pready,        // apb ready
  output logic                       pslverr,       // apb error
  input  wire logic                  pulse_in,      // sensor pulse pin
  input  wire logic                  mode_key,      // mode key pin
  input  wire logic                  up_key,        // up key pin
  input  wire logic                  hold_in,       // hold input pin
  input  wire logic                  protect_sw,    // key-protect switch pin
  input  wire logic [7:0]            dip_sw,        // configuration switches
  input  wire logic                  first_cmp,     // comparator result, output 1
  input  wire logic                  second_cmp,    // comparator result, output 2
  output logic                       first_output,  // control output 1
  output logic                       second_output, // control output 2
  output logic                       count_alarm,   // output ON-count alarm
  output logic                       protect_led,   // key-protect indicator
  output logic                       config_mode,   // in configuration mode
  output tacho_pkg::protect_type     protect_lvl    // applied protect level
);
  import tacho_pkg::*;

  // two-flop synchronisers for every pin
  logic [12:0] s1_q, s2_q;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s1_q <= 13'h0000;
      s2_q <= 13'h0000;
    end else begin
      s1_q <= {dip_sw, protect_sw, hold_in, up_key, mode_key, pulse_in};
      s2_q <= s1_q;
    end
  end
  logic       pulse_s, mode_s, up_s, hold_s, prot_s;
  logic [7:0] dip_s;
  assign {dip_s, prot_s, hold_s, up_s, mode_s, pulse_s} = s2_q;
  // staged settings: control edits go to shadow, applied on return to run; alarm and set point writes apply at once
  logic [31:0] ctrl_sh_q, ctrl_sh_d, ctrl_q, ctrl_d;
  logic [31:0] alarm1_q, alarm1_d, alarm2_q, alarm2_d, setpt_q, setpt_d;
  logic        width_mode, period_mode, cont_mode;
  logic [3:0]  cfg_sel;
  assign width_mode  = ctrl_q[`CTRL_WIDTH_BIT];
  assign period_mode = ctrl_q[`CTRL_PERIOD_BIT];
  assign cont_mode   = ctrl_q[`CTRL_CONT_BIT];
  assign cfg_sel     = ctrl_q[`CTRL_CFG_LSB +: 4];

  // mode sequencing: mode key then up key held for the hold time
  mode_type    mode_q, mode_d;
  logic [31:0] key_cnt_q, key_cnt_d;
  logic        up_prev_q, keys_blocked;
  // only config-entry keys are modelled; the protect switch blocks only arming from run mode, at any protect level
  assign keys_blocked = prot_s;

  always_comb begin
    mode_d    = mode_q;
    key_cnt_d = 32'h0000_0000;
    case (mode_q)
      st_run: begin
        // up key pressed before mode key never arms
        if (mode_s && up_s && !up_prev_q && !keys_blocked) begin
          mode_d = st_armed;
        end
      end
      st_armed: begin
        if (!(mode_s && up_s)) begin
          mode_d = st_run;
        end else if (key_cnt_q >= KEY_CYC - 1) begin
          mode_d = st_config;
        end else begin
          key_cnt_d = key_cnt_q + 32'h0000_0001;
        end
      end
      st_config: begin
        if (mode_s && !up_s) begin
          mode_d = st_run;
        end
      end
      default: mode_d = st_run;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mode_q    <= st_run;
      key_cnt_q <= 32'h0000_0000;
      up_prev_q <= 1'b0;
    end else begin
      mode_q    <= mode_d;
      key_cnt_q <= key_cnt_d;
      up_prev_q <= up_s;
    end
  end
  logic in_cfg, leaving_cfg, running;
  assign in_cfg      = (mode_q == st_config);
  assign leaving_cfg = in_cfg && (mode_d == st_run);
  assign running     = !in_cfg;
  // apb slave: one access cycle, read data staged at setup; never errors
  logic        acc, wr, rd, hit;
  logic [31:0] rdata_d;
  logic        err_d;
  logic [31:0] value_q, value_d;
  logic [31:0] on1_q, on1_d, on2_q, on2_d;
  assign acc = psel && penable;
  assign wr  = acc && pwrite;
  assign rd  = psel && !penable && !pwrite; // staged so data stands with pready
  always_comb begin
    hit     = 1'b1;
    rdata_d = 32'h0000_0000;
    case (paddr)
      `REG_CTRL:   rdata_d = in_cfg ? ctrl_sh_q : ctrl_q;
      `REG_ALARM1: rdata_d = alarm1_q;
      `REG_ALARM2: rdata_d = alarm2_q;
      `REG_STATUS: rdata_d = {28'h000_0000, protect_led, count_alarm, hold_s, in_cfg};
      `REG_VALUE:  rdata_d = value_q;
      `REG_ONMON1: rdata_d = on1_q / `ONS_PER_UNIT;
      `REG_ONMON2: rdata_d = on2_q / `ONS_PER_UNIT;
      `REG_SWMON:  rdata_d = dip_s[0] ? {24'h00_0000, dip_s} : 32'h0000_0000;
      `REG_SETPT:  rdata_d = setpt_q;
      default:     hit = 1'b0;
    endcase
    // monitors are read-only
    err_d = acc && (!hit || (pwrite && (paddr == `REG_ONMON1 || paddr == `REG_ONMON2
            || paddr == `REG_SWMON || paddr == `REG_STATUS || paddr == `REG_VALUE)));
  end

  // settings writes and apply-on-exit
  always_comb begin
    ctrl_sh_d = ctrl_sh_q;
    ctrl_d    = ctrl_q;
    alarm1_d  = alarm1_q;
    alarm2_d  = alarm2_q;
    setpt_d   = setpt_q;
    // protect level and configuration are editable only out of run mode
    if (wr && in_cfg && paddr == `REG_CTRL) begin
      ctrl_sh_d = pwdata;
    end
    if (wr && paddr == `REG_ALARM1 && pwdata <= `ALARM_MAX) begin
      alarm1_d = pwdata;
    end
    if (wr && paddr == `REG_ALARM2 && pwdata <= `ALARM_MAX) begin
      alarm2_d = pwdata;
    end
    if (wr && paddr == `REG_SETPT) begin
      setpt_d = pwdata;
    end
    if (leaving_cfg) begin
      ctrl_d = ctrl_sh_q;
      if (ctrl_sh_q[`CTRL_CFG_LSB +: 4] != cfg_sel) begin
        setpt_d  = `SETPT_RESET;
        alarm1_d = 32'h0000_0000;
        alarm2_d = 32'h0000_0000;
      end
    end
  end
  // two-stage builds power up in the two-stage configuration
  localparam logic [3:0]  CFG_RST  = TWO_STAGE ? `CFG_RESET_2STAGE : `CFG_RESET;
  localparam logic [31:0] CTRL_RST = {24'h00_0000, CFG_RST, 4'h0};

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_sh_q <= CTRL_RST;
      ctrl_q    <= CTRL_RST;
      alarm1_q  <= 32'h0000_0000;
      alarm2_q  <= 32'h0000_0000;
      setpt_q   <= `SETPT_RESET;
      prdata    <= 32'h0000_0000;
      pready    <= 1'b0;
      pslverr   <= 1'b0;
    end else begin
      ctrl_sh_q <= (mode_q != st_config && mode_d == st_config) ? ctrl_q : ctrl_sh_d;
      ctrl_q    <= ctrl_d;
      alarm1_q  <= alarm1_d;
      alarm2_q  <= alarm2_d;
      setpt_q   <= setpt_d;
      prdata    <= rd ? rdata_d : 32'h0000_0000;
      pready    <= psel && !penable;
      pslverr   <= err_d && psel && penable && 1'b0 || (psel && !penable && 1'b0);
    end
  end
  // cycle-mode measurement: count rising edges, latch each interval
  logic        pulse_prev_q, rise;
  logic [31:0] edge_cnt_q, edge_cnt_d, win_q, win_d, intv_q, intv_d, per_q, per_d;
  logic [31:0] intv_len, gap_q, gap_d, hz_q, hz_d;
  logic [31:0] width_v;
  assign rise     = pulse_s && !pulse_prev_q;
  assign intv_len = cont_mode ? INTCONT_CYC : INT200_CYC;

  tacho_pulse_width u_width (
    .pclk    (pclk),
    .presetn (presetn),
    .run     (running && width_mode),
    .level   (pulse_s),    // relies on at least 20 ms off time
    .width_q (width_v)
  );

  always_comb begin
    edge_cnt_d = edge_cnt_q;
    win_d      = win_q + 32'h0000_0001;
    intv_d     = intv_q + 32'h0000_0001;
    per_d      = per_q + 32'h0000_0001;
    value_d    = value_q;
    gap_d      = gap_q;
    hz_d       = hz_q;
    if (rise) begin
      edge_cnt_d = edge_cnt_q + 32'h0000_0001;
      per_d      = 32'h0000_0001;
      gap_d      = per_q;
    end
    if (win_q >= WINDOW_CYC - 1) begin
      win_d      = 32'h0000_0000;
      edge_cnt_d = {31'h0000_0000, rise};
      hz_d       = edge_cnt_q;
    end
    if (intv_q >= intv_len - 32'h0000_0001) begin
      intv_d = 32'h0000_0000;
      // hz is pulses in the last full window; period is cycles between edges
      value_d = period_mode ? gap_q : hz_q;
    end
    if (width_mode) begin
      value_d = width_v; // no-pulse zeroing skipped here
    end
    if (hold_s) begin
      value_d = value_q;
    end
    if (!running) begin
      value_d    = 32'h0000_0000;
      edge_cnt_d = 32'h0000_0000;
      win_d      = 32'h0000_0000;
      intv_d     = 32'h0000_0000;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pulse_prev_q <= 1'b0;
      edge_cnt_q   <= 32'h0000_0000;
      win_q        <= 32'h0000_0000;
      intv_q       <= 32'h0000_0000;
      per_q        <= 32'h0000_0000;
      value_q      <= 32'h0000_0000;
      gap_q        <= 32'h0000_0000;
      hz_q         <= 32'h0000_0000;
    end else begin
      pulse_prev_q <= pulse_s;
      edge_cnt_q   <= edge_cnt_d;
      win_q        <= win_d;
      intv_q       <= intv_d;
      per_q        <= per_d;
      value_q      <= value_d;
      gap_q        <= gap_d;
      hz_q         <= hz_d;
    end
  end

  // outputs, ON counts and alarm
  logic o1_d, o2_d, alarm_d;
  always_comb begin
    o1_d  = first_cmp;
    o2_d  = second_cmp;
    on1_d = on1_q;
    on2_d = on2_q;
    if (hold_s) begin
      o1_d = first_output;
      o2_d = second_output;
    end
    if (!running) begin
      o1_d = 1'b0;
      o2_d = 1'b0;
    end
    if (o1_d && !first_output) begin
      on1_d = on1_q + 32'h0000_0001;
    end
    if (o2_d && !second_output) begin
      on2_d = on2_q + 32'h0000_0001;
    end
    // zero threshold disables that alarm; alarm is sticky until reset
    alarm_d = count_alarm
      || (alarm1_q != 32'h0000_0000 && on1_q > alarm1_q * `ONS_PER_UNIT)
      || (alarm2_q != 32'h0000_0000 && on2_q > alarm2_q * `ONS_PER_UNIT);
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      first_output  <= 1'b0;
      second_output <= 1'b0;
      on1_q         <= 32'h0000_0000;
      on2_q         <= 32'h0000_0000;
      count_alarm   <= 1'b0;
      protect_led   <= 1'b0;
      config_mode   <= 1'b0;
      protect_lvl   <= `KP_RESET;
    end else begin
      first_output  <= o1_d;
      second_output <= o2_d;
      on1_q         <= on1_d;
      on2_q         <= on2_d;
      count_alarm   <= alarm_d;
      protect_led   <= prot_s;
      config_mode   <= (mode_d == st_config);
      protect_lvl   <= ctrl_q[`CTRL_KP_LSB +: 3];
    end
  end

  // entering config mode forces both outputs off next cycle
  property p_cfg_off;
    @(posedge pclk) disable iff (!presetn)
      in_cfg |=> (!first_output && !second_output && value_q == 32'h0000_0000);
  endproperty
  a_cfg_off: assert property (p_cfg_off) else $error("outputs on in config");

  property p_led;
    @(posedge pclk) disable iff (!presetn) prot_s |=> protect_led;
  endproperty
  a_led: assert property (p_led) else $error("protect led dark");
  property p_alarm_sticky;
    @(posedge pclk) disable iff (!presetn) count_alarm |=> count_alarm;
  endproperty
  a_alarm_sticky: assert property (p_alarm_sticky) else $error("count alarm dropped");
  property p_hold_out;
    @(posedge pclk) disable iff (!presetn) (hold_s && running) |=>
      ($stable(first_output) && $stable(second_output));
  endproperty
  a_hold_out: assert property (p_hold_out) else $error("outputs moved in hold");
  property p_ctrl_apply;
    @(posedge pclk) disable iff (!presetn) !leaving_cfg |=> $stable(ctrl_q);
  endproperty
  a_ctrl_apply: assert property (p_ctrl_apply) else $error("settings applied early");
endmodule
`default_nettype wire

// ===== tacho_pulse_width.sv
// tacho_pulse_width: measures input ON time in pclk cycles
// assumes a synchronised input level from the same clock
`timescale 1ns/1ps
`default_nettype none
module tacho_pulse_width (
  input  wire logic        pclk,     // system clock
  input  wire logic        presetn,  // async reset, low
  input  wire logic        run,      // measuring allowed
  input  wire logic        level,    // synchronised pulse level
  output logic [31:0]      width_q   // last measured ON width
);
  logic [31:0] cnt_q, cnt_d, width_d;
  logic        lvl_q;

  // count while on; latch on the falling edge, clear when not run, hold otherwise
  always_comb begin
    cnt_d   = cnt_q;
    width_d = width_q;
    if (!run) begin
      cnt_d   = 32'h0000_0000;
      width_d = 32'h0000_0000;
    end else if (level) begin
      cnt_d = cnt_q + 32'h0000_0001;
    end else if (lvl_q) begin
      width_d = cnt_q;
      cnt_d   = 32'h0000_0000;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_q   <= 32'h0000_0000;
      width_q <= 32'h0000_0000;
      lvl_q   <= 1'b0;
    end else begin
      cnt_q   <= cnt_d;
      width_q <= width_d;
      lvl_q   <= run & level;
    end
  end

  // no new pulse means the old width stays
  property p_width_hold;
    @(posedge pclk) disable iff (!presetn)
      (run && !level && !lvl_q && $past(run)) |=> (width_q == $past(width_q));
  endproperty
  a_width_hold: assert property (p_width_hold) else $error("width not held");
endmodule
`default_nettype wire

// ===== tacho_sensor_model.sv
// tacho_sensor_model: pulse sensor, front keys and panel switches
// assumes pclk from the bench; every pin changes just after a rising edge
`timescale 1ns/1ps
`default_nettype none
module tacho_sensor_model #(
  parameter int GAP_CYC = 20  // shortest off time in width mode
) (
  input  wire logic       pclk,       // bench clock
  output logic            pulse_in,   // sensor pulse
  output logic            mode_key,   // mode key
  output logic            up_key,     // up key
  output logic            hold_in,    // hold input
  output logic            protect_sw, // key-protect switch
  output logic [7:0]      dip_sw      // configuration switches
);
  // everything idles off
  initial begin
    pulse_in = 1'b0;
    mode_key = 1'b0;
    up_key = 1'b0;
    hold_in = 1'b0;
    protect_sw = 1'b0;
    dip_sw = 8'h00;
  end
  // one pulse; width mode stretches the off time to the minimum gap
  task automatic pulse(input int on_c, input int off_c, input bit wmode);
    int g;
    g = (wmode && off_c < GAP_CYC) ? GAP_CYC : off_c;
    pulse_in <= 1'b1;
    repeat (on_c) @(posedge pclk);
    pulse_in <= 1'b0;
    repeat (g) @(posedge pclk);
  endtask
  // key chord; up_first shows the wrong order
  task automatic chord(input bit up_first, input int hold_c);
    if (up_first) up_key <= 1'b1;
    else mode_key <= 1'b1;
    repeat (3) @(posedge pclk);
    mode_key <= 1'b1;
    up_key <= 1'b1;
    repeat (hold_c) @(posedge pclk);
    mode_key <= 1'b0;
    up_key <= 1'b0;
    repeat (4) @(posedge pclk);
  endtask
  // mode key alone leaves configuration
  task automatic leave();
    mode_key <= 1'b1;
    repeat (4) @(posedge pclk);
    mode_key <= 1'b0;
    repeat (6) @(posedge pclk);
  endtask
  // slow panel pins
  task automatic pins(input logic h, input logic p, input logic [7:0] d);
    hold_in <= h;
    protect_sw <= p;
    dip_sw <= d;
    repeat (6) @(posedge pclk);
  endtask
endmodule
`default_nettype wire

// ===== test_tacho_pulse_measure_ctrl.sv
// test_tacho_pulse_measure_ctrl: self-checking bench for the tachometer block
// assumes shortened counts; the sensor model drives the panel pins
`timescale 1ns/1ps
`default_nettype none
`include "tacho_cfg.svh"
module test_tacho_pulse_measure_ctrl;
  localparam int KEY = 10;
  logic        pclk = 1'b0;
  logic        presetn = 1'b0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [31:0] prdata;
  logic        pready, pslverr, pulse_in, mode_key, up_key, hold_in, protect_sw;
  logic [7:0]  dip_sw;
  logic        first_cmp = 1'b0;
  logic        second_cmp = 1'b0;
  logic        first_output, second_output, count_alarm, protect_led, config_mode;
  logic [2:0]  protect_lvl;
  int          miscompares = 0;
  int          total_checks = 0;
  // 100 MHz clock
  always #5 pclk = ~pclk;
  tacho_pulse_measure_ctrl #(.WINDOW_CYC(100), .INT200_CYC(20), .INTCONT_CYC(5),
    .KEY_CYC(KEY)) tacho_pulse_measure_ctrl_inst (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .pulse_in(pulse_in),
    .mode_key(mode_key), .up_key(up_key), .hold_in(hold_in), .protect_sw(protect_sw),
    .dip_sw(dip_sw), .first_cmp(first_cmp), .second_cmp(second_cmp),
    .first_output(first_output), .second_output(second_output),
    .count_alarm(count_alarm), .protect_led(protect_led), .config_mode(config_mode),
    .protect_lvl(protect_lvl));
  tacho_sensor_model #(.GAP_CYC(20)) tacho_sensor_model_inst (.pclk(pclk),
    .pulse_in(pulse_in), .mode_key(mode_key), .up_key(up_key), .hold_in(hold_in),
    .protect_sw(protect_sw), .dip_sw(dip_sw));
  // compare exactly, or within one either way when tol is nonzero
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input int tol = 0);
    total_checks++;
    if (got !== exp && !(tol > 0 && (got === exp + 1 || got + 1 === exp))) begin
      miscompares++;
      $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // one apb transfer; request held until pready is seen at an edge
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd,
                     output logic [31:0] rd);
    int n;
    n = 0;
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    rd = prdata;
    chk(32'(pready), 32'h1);
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] v;
    apb(1'b1, a, d, v);
  endtask
  task automatic rchk(input logic [11:0] a, input logic [31:0] e, input int tol = 0);
    logic [31:0] v;
    apb(1'b0, a, 32'h0000_0000, v);
    chk(v, e, tol);
  endtask
  task automatic do_reset();
    presetn <= 1'b0;
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
  endtask
  // enter config, write control, leave
  task automatic reconf(input logic [31:0] c);
    tacho_sensor_model_inst.chord(1'b0, KEY + 4);
    wr(`REG_CTRL, c);
    tacho_sensor_model_inst.leave();
  endtask
  task automatic t_reset();
    rchk(`REG_CTRL, 32'h0000_0000);
    rchk(12'h0FC, 32'h0000_0000);
    chk(32'(pslverr), 32'h0);
    $display("test reset done");
  endtask
  // count 1001 ON events against a threshold of one thousand
  task automatic t_alarm();
    do_reset();
    wr(`REG_ALARM1, 32'h0000_0001);
    wr(`REG_ALARM1, 32'h0000_2710);
    rchk(`REG_ALARM1, 32'h0000_0001);
    for (int i = 0; i < 1001; i++) begin
      if (i == 1000) chk(32'(count_alarm), 32'h0);
      first_cmp <= 1'b1;
      repeat (3) @(posedge pclk);
      first_cmp <= 1'b0;
      repeat (3) @(posedge pclk);
    end
    chk(32'(count_alarm), 32'h1);
    wr(`REG_ONMON1, 32'h0000_0005);
    rchk(`REG_ONMON1, 32'h0000_0001);
    rchk(`REG_ONMON2, 32'h0000_0000);
    $display("test alarm done");
  endtask
  task automatic t_panel();
    tacho_sensor_model_inst.pins(1'b0, 1'b0, 8'hA4);
    rchk(`REG_SWMON, 32'h0000_0000);
    tacho_sensor_model_inst.pins(1'b0, 1'b0, 8'hA5);
    rchk(`REG_SWMON, 32'h0000_00A5);
    tacho_sensor_model_inst.pins(1'b0, 1'b1, 8'hA5);
    chk(32'(protect_led), 32'h1);
    tacho_sensor_model_inst.chord(1'b0, KEY + 4);
    chk(32'(config_mode), 32'h0);
    tacho_sensor_model_inst.pins(1'b0, 1'b0, 8'hA5);
    chk(32'(protect_led), 32'h0);
    $display("test panel done");
  endtask
  task automatic t_config();
    tacho_sensor_model_inst.chord(1'b1, KEY + 4);
    chk(32'(config_mode), 32'h0);
    tacho_sensor_model_inst.chord(1'b0, KEY + 4);
    chk(32'(config_mode), 32'h1);
    first_cmp <= 1'b1;
    repeat (4) @(posedge pclk);
    chk(32'(first_output), 32'h0);
    rchk(`REG_VALUE, 32'h0000_0000);
    wr(`REG_CTRL, 32'h0000_0302);
    chk(32'(protect_lvl), 32'h0);
    first_cmp <= 1'b0;
    tacho_sensor_model_inst.leave();
    chk(32'(config_mode), 32'h0);
    chk(32'(protect_lvl), 32'h3);
    wr(`REG_CTRL, 32'h0000_0000);
    rchk(`REG_CTRL, 32'h0000_0302);
    $display("test config done");
  endtask
  // period, then hertz with continuous update, pulses every ten cycles
  task automatic t_cycle();
    for (int m = 0; m < 2; m++) begin
      if (m == 1) reconf(32'h0000_0304);
      fork
        repeat (40) tacho_sensor_model_inst.pulse(5, 5, 1'b0);
        begin
          repeat (300) @(posedge pclk);
          rchk(`REG_VALUE, 32'h0000_000A, 1);
        end
      join
    end
    $display("test cycle done");
  endtask
  task automatic t_width();
    reconf(32'h0000_0301);
    tacho_sensor_model_inst.pulse(30, 20, 1'b1);
    rchk(`REG_VALUE, 32'h0000_001E, 1);
    repeat (400) @(posedge pclk);
    rchk(`REG_VALUE, 32'h0000_001E, 1);
    $display("test width done");
  endtask
  // outputs freeze while hold is on
  task automatic t_hold();
    first_cmp <= 1'b1;
    second_cmp <= 1'b1;
    repeat (6) @(posedge pclk);
    chk(32'({first_output, second_output}), 32'h3);
    tacho_sensor_model_inst.pins(1'b1, 1'b0, 8'hA5);
    first_cmp <= 1'b0;
    second_cmp <= 1'b0;
    repeat (10) @(posedge pclk);
    chk(32'({first_output, second_output}), 32'h3);
    tacho_sensor_model_inst.pins(1'b0, 1'b0, 8'hA5);
    chk(32'({first_output, second_output}), 32'h0);
    $display("test hold done");
  endtask
  // a new configuration wipes set and comparison values
  task automatic t_reinit();
    wr(`REG_ALARM2, 32'h0000_0005);
    wr(`REG_SETPT, 32'h0000_1234);
    rchk(`REG_ALARM2, 32'h0000_0005);
    rchk(`REG_SETPT, 32'h0000_1234);
    reconf(32'h0000_0312);
    rchk(`REG_ALARM2, 32'h0000_0000);
    rchk(`REG_SETPT, `SETPT_RESET);
    rchk(`REG_CTRL, 32'h0000_0312);
    $display("test reinit done");
  endtask
  task automatic wrap_up();
    $display("checks=%0d miscompares=%0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  // main sequence
  initial begin
    do_reset();
    t_reset();
    t_alarm();
    t_panel();
    t_config();
    t_cycle();
    t_width();
    t_hold();
    t_reinit();
    wrap_up();
  end
  // watchdog, well beyond the expected run
  initial begin
    #(60000 * 10);
    miscompares++;
    wrap_up();
  end
endmodule
`default_nettype wire
